// >>> dv/acr_conv_ctrl_tb.sv
// self-checking bench for the converter control block
// assumes default step counts; comparator stands in for the analog input
`timescale 1ns/1ps
module acr_conv_ctrl_tb;
  localparam int MIN_CYC = acr_pkg::MIN_CONV_US * acr_pkg::CLK_MHZ;
  logic              clk, rst, busy_n, data_oe, az_active, cmp_above;
  logic [11:0]       ain, trial_code;
  logic [7:0]        data_out, d;
  acr_pkg::acr_bus_s bus;
  int                num_errors, cmp_count, n;

  acr_conv_ctrl u_acr_conv_ctrl (.clk(clk), .rst(rst), .bus(bus), .cmp_above(cmp_above),
    .busy_n(busy_n), .data_out(data_out), .data_oe(data_oe), .trial_code(trial_code),
    .az_active(az_active));
  acr_host_model u_acr_host_model (.clk(clk), .data_out(data_out), .data_oe(data_oe),
    .bus(bus));
  // comparator: input at or above the trial code
  assign cmp_above = (ain >= trial_code);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task results;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task wait_done;
    n = 0;
    while (busy_n !== 1'b1 && n < 13000)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_done

  task read_res(input logic [11:0] exp);
    u_acr_host_model.read(1'b0, d);
    chk(d, exp[7:0], "low byte");
    u_acr_host_model.read(1'b1, d);
    chk(d, {4'h0, exp[11:8]}, "high byte");
    @(posedge clk);
    #1 chk(data_oe, 0, "bus released");
  endtask : read_res

  // ****************************************
  // scenarios
  // ****************************************
  task t_poll(input logic [11:0] a);
    ain = a;
    u_acr_host_model.start();
    chk(busy_n, 0, "busy after start");
    chk(az_active, 1, "auto-zero after start");
    u_acr_host_model.read(1'b1, d);
    chk(d, 8'h80, "flag while converting");
    n = 0;
    do u_acr_host_model.read(1'b1, d); while (d[7] !== 1'b0 && ++n < 10000);
    chk(d, {4'h0, a[11:8]}, "polled high byte");
    u_acr_host_model.read(1'b0, d);
    chk(d, a[7:0], "polled low byte");
  endtask : t_poll

  task t_timed(input logic [11:0] a);
    ain = a;
    u_acr_host_model.start();
    wait_done();
    chk(n >= MIN_CYC, 1, "too fast");
    chk(n < 13000, 1, "busy stuck");
    chk(az_active, 0, "auto-zero over");
    read_res(a);
  endtask : t_timed

  task t_delay(input logic [11:0] a);
    ain = a;
    u_acr_host_model.start();
    repeat (12600) @(posedge clk);
    read_res(a);
  endtask : t_delay

  task t_restart;
    ain = 12'hF23;
    u_acr_host_model.start();
    repeat (3000) @(posedge clk);
    ain = 12'h9AB;
    u_acr_host_model.start();
    chk(busy_n, 0, "busy after restart");
    u_acr_host_model.read(1'b1, d);
    chk(d, 8'h80, "restart clears result");
    wait_done();
    chk(n >= MIN_CYC, 1, "restart too fast");
    read_res(12'h9AB);
    ain = 12'h000;
    repeat (50) @(posedge clk);
    read_res(12'h9AB);
    chk(busy_n, 1, "idle busy");
  endtask : t_restart

  initial
  begin
    rst = 1'b1;
    ain = 12'h000;
    num_errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    t_poll(12'hA5C);
    t_timed(12'h001);
    t_timed(12'hFFF);
    t_delay(12'h800);
    t_restart();
    results();
  end

  initial
  begin
    repeat (85000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule : acr_conv_ctrl_tb

// >>> dv/acr_host_model.sv
// host bus model: start strobes and byte reads on the converter control
// assumes read data is registered one cycle after the strobes are sampled
`timescale 1ns/1ps
module acr_host_model (
  input  wire logic         clk,      // system clock
  input  wire logic [7:0]   data_out, // read data
  input  wire logic         data_oe,  // bus driven
  output acr_pkg::acr_bus_s bus       // host strobes
);
  initial bus = 4'hF;

  task start;
    @(posedge clk);
    #1 bus.chip_sel_n = 1'b0;
    bus.write_n = 1'b0;
    @(posedge clk);
    #1 bus.write_n = 1'b1;
    bus.chip_sel_n = 1'b1;
  endtask : start

  task read(input logic bc, output logic [7:0] d);
    int n;
    @(posedge clk);
    #1 bus.chip_sel_n = 1'b0;
    bus.read_n = 1'b0;
    bus.byte_choose = bc;
    n = 0;
    do @(posedge clk); while (data_oe !== 1'b1 && ++n < 8);
    d = (data_oe === 1'b1) ? data_out : 8'hXX;
    #1 bus.read_n = 1'b1;
    bus.chip_sel_n = 1'b1;
  endtask : read
endmodule : acr_host_model

// >>> hw/acr_conv_ctrl.sv
// conversion control and result readout of a 12-bit successive-approximation converter
// assumes bus strobes synchronous to clk; comparator input comes from the analog front end
`timescale 1ns/1ps

// Contract
// - busy_n low for the whole conversion, high once finished.
// - high-byte read puts the status flag on bit seven, high while converting.
// - a start during a conversion abandons it and restarts from the beginning.
// - result is natural binary, one step is full scale over 4096.
// - code transitions on integer step multiples, from zero up to all ones.
// - conversion never completes faster than 100 microseconds.
// - byte_choose high gives flag, three zeros, bits 11..8; low gives bits 7..0.
// - read during conversion returns the partial approximation register contents.
// - start while select and write low; twelve decision steps follow the strobe.
module acr_conv_ctrl #(
  parameter int STEP_CYC = acr_pkg::STEP_CYC,
  parameter int AZ_CYC   = acr_pkg::AZ_CYC
) (
  input  wire logic                      clk,         // 125 MHz clock
  input  wire logic                      rst,         // synchronous reset
  input  wire acr_pkg::acr_bus_s         bus,         // host strobes
  input  wire logic                      cmp_above,   // comparator: input at or above trial
  output logic                           busy_n,      // low while converting
  output logic [acr_pkg::DATA_W-1:0]     data_out,    // read data
  output logic                           data_oe,     // bus driven
  output logic [acr_pkg::RES_W-1:0]      trial_code,  // trial value to the dac
  output logic                           az_active    // auto-zero phase
);

  localparam int BW    = $clog2(acr_pkg::RES_W);
  localparam int AZW   = $clog2(AZ_CYC + 1);
  localparam int RUN_W = $clog2(STEP_CYC * acr_pkg::RES_W + AZ_CYC + 4);

  if (STEP_CYC * acr_pkg::RES_W + AZ_CYC < acr_pkg::MIN_CONV_US * acr_pkg::CLK_MHZ)
  begin : g_bad
    $error("acr_conv_ctrl: conversion shorter than the minimum");
  end

  // ***********************************************************
  // decode
  // ***********************************************************
  acr_pkg::acr_state_e        st_ff;
  acr_pkg::acr_state_e        nxt_st;
  logic [acr_pkg::RES_W-1:0]  sar_ff;
  logic [acr_pkg::RES_W-1:0]  nxt_sar;
  logic [BW-1:0]              bit_ff;
  logic [BW-1:0]              nxt_bit;
  logic [AZW-1:0]             az_ff;
  logic [AZW-1:0]             nxt_az;
  logic                       step_tick;
  logic                       start_req;
  logic                       read_req;
  logic                       converting;
  logic                       az_done;
  logic                       last_bit;
  logic [acr_pkg::RES_W-1:0]  bit_mask;
  logic [acr_pkg::RES_W-1:0]  trial;
  logic [acr_pkg::DATA_W-1:0] hi_byte;
  logic [acr_pkg::DATA_W-1:0] lo_byte;

  assign start_req  = !bus.chip_sel_n && !bus.write_n;
  assign read_req   = !bus.chip_sel_n && !bus.read_n;
  assign converting = (st_ff != acr_pkg::ST_IDLE);
  assign az_done    = (az_ff == '0);
  assign last_bit   = (bit_ff == '0);
  assign bit_mask   = acr_pkg::RES_W'(1) << bit_ff;
  assign trial      = sar_ff | bit_mask;
  // natural binary, msb first; comparator decides each step
  assign hi_byte = {converting, {acr_pkg::HI_ZERO_W{1'b0}},
                    sar_ff[acr_pkg::RES_W-1:acr_pkg::DATA_W]};
  assign lo_byte = sar_ff[acr_pkg::DATA_W-1:0];

  // ***********************************************************
  // sequencer
  // ***********************************************************
  acr_divider #(
    .PERIOD (STEP_CYC)
  ) u_step (
    .clk     (clk),
    .rst     (rst),
    .restart (st_ff != acr_pkg::ST_SAR),
    .tick    (step_tick)
  );

  always_comb
  begin
    nxt_st  = st_ff;
    nxt_sar = sar_ff;
    nxt_bit = bit_ff;
    nxt_az  = az_ff;
    if (start_req)
    begin
      // strobe held low: stay in start, abandoning any conversion
      nxt_st  = acr_pkg::ST_START;
      nxt_sar = '0;
      nxt_bit = BW'(acr_pkg::RES_W - 1);
      nxt_az  = AZW'(AZ_CYC);
    end
    else
    begin
      unique case (st_ff)
        acr_pkg::ST_IDLE:  nxt_st = acr_pkg::ST_IDLE;
        acr_pkg::ST_START: nxt_st = acr_pkg::ST_AZERO;
        acr_pkg::ST_AZERO:
        begin
          if (az_done)
            nxt_st = acr_pkg::ST_SAR;
          else
            nxt_az = az_ff - 1'b1;
        end
        acr_pkg::ST_SAR:
        begin
          if (step_tick)
          begin
            nxt_sar = cmp_above ? trial : sar_ff;
            nxt_bit = bit_ff - 1'b1;
            if (last_bit)
              nxt_st = acr_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff  <= acr_pkg::ST_IDLE;
      sar_ff <= '0;
      bit_ff <= '0;
      az_ff  <= '0;
    end
    else
    begin
      st_ff  <= nxt_st;
      sar_ff <= nxt_sar;
      bit_ff <= nxt_bit;
      az_ff  <= nxt_az;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_n     <= 1'b1;
      data_out   <= '0;
      data_oe    <= 1'b0;
      trial_code <= '0;
      az_active  <= 1'b0;
    end
    else
    begin
      busy_n     <= !(nxt_st != acr_pkg::ST_IDLE);
      data_oe    <= read_req;
      data_out   <= bus.byte_choose ? hi_byte : lo_byte;
      trial_code <= (nxt_st == acr_pkg::ST_SAR) ? (nxt_sar | (acr_pkg::RES_W'(1) << nxt_bit))
                                                 : nxt_sar;
      az_active  <= (nxt_st == acr_pkg::ST_START) || (nxt_st == acr_pkg::ST_AZERO);
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  logic [RUN_W-1:0] run_ff;
  logic [AZW:0]     az_run_ff;
  always_ff @(posedge clk)
  begin
    if (rst || start_req)
      run_ff <= '0;
    else if (converting && (&run_ff) == 1'b0)
      run_ff <= run_ff + 1'b1;
  end

  // cycles spent in the auto-zero phase, saturating
  always_ff @(posedge clk)
  begin
    if (rst || st_ff != acr_pkg::ST_AZERO)
      az_run_ff <= '0;
    else if ((&az_run_ff) == 1'b0)
      az_run_ff <= az_run_ff + 1'b1;
  end

  property p_busy_tracks;
    @(posedge clk) disable iff (rst) ##1 (busy_n == !converting);
  endproperty
  a_busy_tracks: assert property (p_busy_tracks)
    else $error("busy_n does not follow conversion state");

  property p_flag_hi;
    @(posedge clk) disable iff (rst)
      (read_req && bus.byte_choose) |=> (data_out[acr_pkg::HI_FLAG_POS] == !$past(busy_n));
  endproperty
  a_flag_hi: assert property (p_flag_hi)
    else $error("status flag on bit seven wrong");

  property p_restart;
    @(posedge clk) disable iff (rst)
      (converting && start_req) |=> (st_ff == acr_pkg::ST_START && sar_ff == '0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("start during conversion did not restart");

  property p_min_time;
    @(posedge clk) disable iff (rst)
      (st_ff == acr_pkg::ST_SAR && nxt_st == acr_pkg::ST_IDLE)
        |-> (run_ff >= RUN_W'(acr_pkg::MIN_CONV_US * acr_pkg::CLK_MHZ - 1));
  endproperty
  a_min_time: assert property (p_min_time)
    else $error("conversion finished too early");

  property p_hi_layout;
    @(posedge clk) disable iff (rst)
      bus.byte_choose |=> (data_out[6:4] == 3'h0 && data_out[3:0] == $past(sar_ff[11:8]));
  endproperty
  a_hi_layout: assert property (p_hi_layout)
    else $error("high byte layout wrong");

  property p_partial;
    @(posedge clk) disable iff (rst)
      (!bus.byte_choose && converting) |=> (data_out == $past(sar_ff[7:0]));
  endproperty
  a_partial: assert property (p_partial)
    else $error("low byte does not show approximation register");

  property p_hold;
    @(posedge clk) disable iff (rst)
      (!converting && !start_req) |=> $stable(sar_ff);
  endproperty
  a_hold: assert property (p_hold)
    else $error("result changed while idle");

  property p_start;
    @(posedge clk) disable iff (rst)
      (st_ff == acr_pkg::ST_START && !start_req) |=> (st_ff == acr_pkg::ST_AZERO);
  endproperty
  a_start: assert property (p_start)
    else $error("conversion did not proceed after start");

  property p_az_len;
    @(posedge clk) disable iff (rst)
      (st_ff == acr_pkg::ST_AZERO) |-> (az_run_ff <= (AZW+1)'(AZ_CYC));
  endproperty
  a_az_len: assert property (p_az_len)
    else $error("auto-zero phase overran");

  property p_az_exit;
    @(posedge clk) disable iff (rst)
      (st_ff == acr_pkg::ST_AZERO && nxt_st == acr_pkg::ST_SAR)
        |-> (az_run_ff == (AZW+1)'(AZ_CYC));
  endproperty
  a_az_exit: assert property (p_az_exit)
    else $error("auto-zero phase length wrong");

endmodule : acr_conv_ctrl

// >>> hw/acr_divider.sv
// one-cycle enable pulse every PERIOD cycles, restartable
// assumes a single clock and synchronous active-high reset
`timescale 1ns/1ps
module acr_divider #(
  parameter int PERIOD = 10
) (
  input  wire logic clk,     // system clock
  input  wire logic rst,     // synchronous reset
  input  wire logic restart, // reload the count
  output logic      tick     // one-cycle pulse
);

  localparam int CW = $clog2(PERIOD + 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          wrap;

  if (PERIOD < 2)
  begin : g_bad
    $error("acr_divider: PERIOD must be at least 2");
  end

  assign wrap    = (cnt_ff == CW'(PERIOD - 1));
  assign nxt_cnt = (restart || wrap) ? '0 : cnt_ff + 1'b1;
  assign tick    = wrap && !restart;

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

endmodule : acr_divider

// >>> hw/acr_pkg.sv
// package for the converter control block: widths, byte layout, timing counts
// assumes a 125 MHz system clock; no software registers
package acr_pkg;

  localparam int RES_W        = 12;                 // result width
  localparam int DATA_W       = 8;                  // bus width
  localparam int CODE_STEPS   = 4096;               // codes per full scale
  localparam int CLK_MHZ      = 125;                // system clock rate
  localparam int MIN_CONV_US  = 100;                // shortest accurate conversion
  localparam int AZ_US        = 10;                 // auto-zero span after start
  localparam int AZ_CYC       = AZ_US * CLK_MHZ;    // least time, exact
  // twelve decisions plus the auto-zero lead share the 100 us minimum
  localparam int STEP_CYC     = ((MIN_CONV_US - AZ_US) * CLK_MHZ + RES_W - 1) / RES_W;
  localparam int HI_FLAG_POS  = 7;                  // status bit in high byte
  localparam int HI_ZERO_W    = 3;                  // zero bits below status

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_AZERO = 2'b10,
    ST_SAR   = 2'b11
  } acr_state_e;

  typedef struct packed
  {
    logic chip_sel_n;   // chip select, low active
    logic write_n;      // start strobe, low active
    logic read_n;       // read strobe, low active
    logic byte_choose;  // high byte when set
  } acr_bus_s;

endpackage : acr_pkg
